// >>> rtl/cpc_defs.svh
// Constants for the cursor position control block
`ifndef CPC_DEFS_SVH
`define CPC_DEFS_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define CPC_CHAR_W        7
`define CPC_COL_W         7
`define CPC_ROW_W         5
`define CPC_DLY_W         23
`define CPC_SYNC_W        14

// ----------------------------------------------------------------------
// Counter limits and reset values
// ----------------------------------------------------------------------
`define CPC_COL_FIRST     7'h00
`define CPC_COL_LAST      7'h47
`define CPC_ROW_FIRST     5'h00
`define CPC_ROW_LAST      5'h18
`define CPC_SYNC_IDLE     14'h3fff

// ----------------------------------------------------------------------
// Character counter decodes that frame a step pulse
// ----------------------------------------------------------------------
`define CPC_STEP_START    7'h4c
`define CPC_STEP_END      7'h52

// ----------------------------------------------------------------------
// Timing (clock rate in Hz, delays in ms)
// ----------------------------------------------------------------------
`define CPC_CLK_HZ        10000000
`define CPC_DEBOUNCE_MS   10
`define CPC_REPEAT_MS     500
`define CPC_MS_CYCLES(ms) ((ms) * (`CPC_CLK_HZ / 1000))

`endif

// >>> rtl/cpc_pkg.sv
// Types shared by the cursor position control block
`default_nettype none
package cpc_pkg;

	// Step pulse generator states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PULSE,
		ST_HELD
	} cpc_step_e;

	// Arrow key conditioner states
	typedef enum logic [1:0] {
		K_OPEN,
		K_SETTLE,
		K_HELD,
		K_REPEAT
	} cpc_key_e;

endpackage
`default_nettype wire

// >>> rtl/cpc_sync.sv
// Two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defs.svh"

module cpc_sync (
	// Clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     rst,
	// Levels
	input  wire logic [`CPC_SYNC_W-1:0]   async_in,
	output logic      [`CPC_SYNC_W-1:0]   sync_out
);
	import cpc_pkg::*;

	logic [`CPC_SYNC_W-1:0] meta_reg;
	logic [`CPC_SYNC_W-1:0] meta_next;
	logic [`CPC_SYNC_W-1:0] hold_reg;
	logic [`CPC_SYNC_W-1:0] hold_next;

	always_comb begin
		meta_next = async_in;
		hold_next = meta_reg;
	end

	// Idle level is high for every command line
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_reg <= `CPC_SYNC_IDLE;
			hold_reg <= `CPC_SYNC_IDLE;
		end else begin
			meta_reg <= meta_next;
			hold_reg <= hold_next;
		end
	end

	assign sync_out = hold_reg;

endmodule
`default_nettype wire

// >>> rtl/cpc_key_cond.sv
// Arrow key debounce and auto-repeat conditioner
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defs.svh"

module cpc_key_cond (
	// Clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    rst,
	// Delays in cycles
	input  wire logic [`CPC_DLY_W-1:0]   settle_cycles,
	input  wire logic [`CPC_DLY_W-1:0]   onset_cycles,
	// Synchronised key and repeat clock
	input  wire logic                    key_n,
	input  wire logic                    repeat_tick,
	// Conditioned outputs
	output logic                         closed,
	output logic                         request
);
	import cpc_pkg::*;

	cpc_key_e               st_reg;
	cpc_key_e               st_next;
	logic [`CPC_DLY_W-1:0]  cnt_reg;
	logic [`CPC_DLY_W-1:0]  cnt_next;
	logic                   closed_reg;
	logic                   closed_next;
	logic                   req_reg;
	logic                   req_next;
	logic                   pressed;

	assign pressed = ~key_n;

	always_comb begin
		st_next  = st_reg;
		cnt_next = cnt_reg + `CPC_DLY_W'(1);
		unique case (st_reg)
			K_OPEN: begin
				cnt_next = '0;
				if (pressed) begin
					st_next = K_SETTLE;
				end
			end
			// Any bounce restarts the settling wait
			K_SETTLE: begin
				if (!pressed) begin
					st_next  = K_OPEN;
					cnt_next = '0;
				end else if (cnt_reg >= settle_cycles - `CPC_DLY_W'(1)) begin
					st_next  = K_HELD;
					cnt_next = '0;
				end
			end
			K_HELD: begin
				if (!pressed) begin
					st_next  = K_OPEN;
					cnt_next = '0;
				end else if (cnt_reg >= onset_cycles - `CPC_DLY_W'(1)) begin
					st_next  = K_REPEAT;
					cnt_next = '0;
				end
			end
			K_REPEAT: begin // RULE15
				cnt_next = '0;
				if (!pressed) begin
					st_next = K_OPEN;
				end
			end
		endcase
		closed_next = (st_next == K_HELD) || (st_next == K_REPEAT);
		req_next    = (st_next == K_HELD) || ((st_next == K_REPEAT) && repeat_tick);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_reg     <= K_OPEN;
			cnt_reg    <= '0;
			closed_reg <= 1'b0;
			req_reg    <= 1'b0;
		end else begin
			st_reg     <= st_next;
			cnt_reg    <= cnt_next;
			closed_reg <= closed_next;
			req_reg    <= req_next;
		end
	end

	assign closed  = closed_reg;
	assign request = req_reg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_release_drops: assert property (!pressed |=> !closed_reg && !req_reg) // RULE13
		else $error("key output stayed up after release");
	a_settle_first: assert property ($rose(closed_reg) |-> $past(st_reg) == K_SETTLE) // RULE13
		else $error("key closure passed without settling");
	a_repeat_gate: assert property ((st_reg == K_REPEAT) && req_reg |-> $past(repeat_tick)) // RULE15
		else $error("repeat request without repeat clock");

endmodule
`default_nettype wire

// >>> rtl/cpc_top.sv
// Cursor column and row counters with host, key, return and home control
// How it works
// [RULE1] Column is a 72-position up/down counter; zero is first position.
// [RULE2] Row is an up/down counter spanning 25 display rows.
// [RULE3] Move-right steers the column up and applies exactly one step.
// [RULE4] Pending move becomes a pulse from character count 76 to 82.
// [RULE5] Column steps only while the step-permit input is high.
// [RULE6] Column zero decode passes steps when counting up.
// [RULE7] Acceptance latch sets at 82, clears on command release; tells host.
// [RULE8] Move-left steers the column down with the same pulse and path.
// [RULE9] Move-up decrements the row by exactly one.
// [RULE10] Row steps blocked at row zero while steering up.
// [RULE11] Row steps blocked at the last (25th) row while steering down.
// [RULE12] Move-down increments the row by one with the same timing.
// [RULE13] Arrow closures wait out a settling delay before requesting a move.
// [RULE14] Debounced key requests share the host command step generation.
// [RULE15] Held key past onset delay repeats at the 7.5 Hz input rate.
// [RULE16] Each arrow key has a closed indication back to the keyboard.
// [RULE17] Carriage return clears column, leaves row alone.
// [RULE18] Power-on reset, host home-up or home key clear both counters.
// [RULE19] Commands and keys idle high and are pulsed low to act.
// [RULE20] Asynchronous inputs are synchronised; delays are parameters.
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defs.svh"

module cpc_top #(
	parameter int unsigned DEBOUNCE_CYCLES = `CPC_MS_CYCLES(`CPC_DEBOUNCE_MS),
	parameter int unsigned REPEAT_CYCLES   = `CPC_MS_CYCLES(`CPC_REPEAT_MS)
) (
	// Clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     rst,
	// Display character counter, same clock domain
	input  wire logic [`CPC_CHAR_W-1:0]   char_count,
	// Host decoded commands, active low
	input  wire logic                     host_right_n,
	input  wire logic                     host_left_n,
	input  wire logic                     host_up_n,
	input  wire logic                     host_down_n,
	input  wire logic                     host_return_n,
	input  wire logic                     host_home_n,
	// Keyboard closures, active low
	input  wire logic                     key_right_n,
	input  wire logic                     key_left_n,
	input  wire logic                     key_up_n,
	input  wire logic                     key_down_n,
	input  wire logic                     key_home_n,
	// Miscellaneous asynchronous levels
	input  wire logic                     power_on_n,
	input  wire logic                     step_permit,
	input  wire logic                     repeat_clk,
	// Cursor position
	output logic      [`CPC_COL_W-1:0]    cursor_col,
	output logic      [`CPC_ROW_W-1:0]    cursor_row,
	// Step pulses and host acceptance
	output logic                          col_pulse,
	output logic                          row_pulse,
	output logic                          cmd_accepted,
	// Arrow closed indications: right, left, up, down
	output logic      [3:0]               arrow_closed
);
	import cpc_pkg::*;

	// ------------------------------------------------------------------
	// Step generator next state, shared by column and row
	// ------------------------------------------------------------------
	function automatic cpc_step_e step_advance(
		input cpc_step_e                st,
		input logic                     pend,
		input logic [`CPC_CHAR_W-1:0]   cnt
	);
		cpc_step_e nx;
		nx = st;
		unique case (st)
			ST_IDLE: begin
				if (pend && (cnt == `CPC_STEP_START)) begin
					nx = ST_PULSE;
				end
			end
			ST_PULSE: begin
				if (cnt == `CPC_STEP_END) begin
					nx = ST_HELD;
				end
			end
			// No retrigger until the request goes away
			ST_HELD: begin
				if (!pend) begin
					nx = ST_IDLE;
				end
			end
			default: begin
				nx = ST_IDLE;
			end
		endcase
		return nx;
	endfunction

	// ------------------------------------------------------------------
	// Input synchronisation
	// ------------------------------------------------------------------
	logic [`CPC_SYNC_W-1:0] raw_in;
	logic [`CPC_SYNC_W-1:0] syn;

	assign raw_in = {repeat_clk, step_permit, power_on_n, key_home_n,
	                 key_down_n, key_up_n, key_left_n, key_right_n,
	                 host_home_n, host_return_n, host_down_n, host_up_n,
	                 host_left_n, host_right_n};

	cpc_sync u_sync ( // RULE20
		.ref_clk  (ref_clk),
		.rst      (rst),
		.async_in (raw_in),
		.sync_out (syn)
	);

	logic       h_right;
	logic       h_left;
	logic       h_up;
	logic       h_down;
	logic       h_return;
	logic       h_home;
	logic [3:0] k_n;
	logic       k_home;
	logic       por;
	logic       permit;
	logic       rep_tick;

	// Active low host, home key and power-on lines turned to active high requests
	always_comb begin
		h_right  = ~syn[0]; // RULE19
		h_left   = ~syn[1];
		h_up     = ~syn[2];
		h_down   = ~syn[3];
		h_return = ~syn[4];
		h_home   = ~syn[5];
		k_n      = syn[9:6];
		k_home   = ~syn[10];
		por      = ~syn[11];
		permit   = syn[12];
		rep_tick = syn[13];
	end

	// ------------------------------------------------------------------
	// Arrow key conditioning
	// ------------------------------------------------------------------
	logic [3:0] key_req;
	logic [3:0] key_closed;

	generate
		for (genvar i = 0; i < 4; i++) begin : g_key
			cpc_key_cond u_key ( // RULE13
				.ref_clk       (ref_clk),
				.rst           (rst),
				.settle_cycles (`CPC_DLY_W'(DEBOUNCE_CYCLES)),
				.onset_cycles  (`CPC_DLY_W'(REPEAT_CYCLES)),
				.key_n         (k_n[i]),
				.repeat_tick   (rep_tick),
				.closed        (key_closed[i]),
				.request       (key_req[i])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// Request merge and steering
	// ------------------------------------------------------------------
	logic col_pend;
	logic col_up;
	logic row_pend;
	logic row_dec;
	logic clr_all;
	logic clr_col;

	always_comb begin
		// Keys feed the same generators as host commands
		col_pend = h_right | h_left | key_req[0] | key_req[1]; // RULE14
		row_pend = h_up | h_down | key_req[2] | key_req[3];    // RULE14
		col_up   = h_right | key_req[0];                       // RULE3 RULE8
		row_dec  = h_up | key_req[2];                          // RULE9 RULE12
		clr_all  = por | h_home | k_home;                      // RULE18
		clr_col  = clr_all | h_return;                         // RULE17
	end

	// ------------------------------------------------------------------
	// Step pulse generators
	// ------------------------------------------------------------------
	cpc_step_e col_st_reg;
	cpc_step_e col_st_next;
	cpc_step_e row_st_reg;
	cpc_step_e row_st_next;
	logic      col_pulse_reg;
	logic      col_pulse_next;
	logic      row_pulse_reg;
	logic      row_pulse_next;
	logic      accept_reg;
	logic      accept_next;
	logic      col_fire;
	logic      row_fire;

	always_comb begin
		col_st_next    = step_advance(col_st_reg, col_pend, char_count); // RULE4
		row_st_next    = step_advance(row_st_reg, row_pend, char_count); // RULE4
		col_fire       = (col_st_reg == ST_IDLE) && (col_st_next == ST_PULSE);
		row_fire       = (row_st_reg == ST_IDLE) && (row_st_next == ST_PULSE);
		col_pulse_next = (col_st_next == ST_PULSE);
		row_pulse_next = (row_st_next == ST_PULSE);
		accept_next    = (col_st_next == ST_HELD) || (row_st_next == ST_HELD); // RULE7
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			col_st_reg    <= ST_IDLE;
			row_st_reg    <= ST_IDLE;
			col_pulse_reg <= 1'b0;
			row_pulse_reg <= 1'b0;
			accept_reg    <= 1'b0;
		end else begin
			col_st_reg    <= col_st_next;
			row_st_reg    <= row_st_next;
			col_pulse_reg <= col_pulse_next;
			row_pulse_reg <= row_pulse_next;
			accept_reg    <= accept_next;
		end
	end

	// ------------------------------------------------------------------
	// Cursor counters
	// ------------------------------------------------------------------
	logic [`CPC_COL_W-1:0] col_reg;
	logic [`CPC_COL_W-1:0] col_next;
	logic [`CPC_ROW_W-1:0] row_reg;
	logic [`CPC_ROW_W-1:0] row_next;
	logic                  col_gate;
	logic                  row_gate;

	always_comb begin
		// Ends of travel hold instead of wrapping
		col_gate = permit && (col_up ? (col_reg != `CPC_COL_LAST)    // RULE5 RULE1
		                             : (col_reg != `CPC_COL_FIRST)); // RULE6
		row_gate = row_dec ? (row_reg != `CPC_ROW_FIRST)             // RULE10
		                   : (row_reg != `CPC_ROW_LAST);             // RULE11
		col_next = col_reg;
		row_next = row_reg;
		if (col_fire && col_gate) begin
			col_next = col_up ? col_reg + `CPC_COL_W'(1)   // RULE3
			                  : col_reg - `CPC_COL_W'(1);  // RULE8
		end
		if (row_fire && row_gate) begin
			row_next = row_dec ? row_reg - `CPC_ROW_W'(1)  // RULE9
			                   : row_reg + `CPC_ROW_W'(1); // RULE12
		end
		// Clears dominate any step in the same cycle
		if (clr_col) begin
			col_next = `CPC_COL_FIRST; // RULE17
		end
		if (clr_all) begin
			row_next = `CPC_ROW_FIRST; // RULE18
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			col_reg <= `CPC_COL_FIRST; // RULE18
			row_reg <= `CPC_ROW_FIRST;
		end else begin
			col_reg <= col_next;
			row_reg <= row_next; // RULE2
		end
	end

	// ------------------------------------------------------------------
	// Key closed indications
	// ------------------------------------------------------------------
	logic [3:0] closed_reg;
	logic [3:0] closed_next;

	always_comb begin
		closed_next = key_closed; // RULE16
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			closed_reg <= 4'h0;
		end else begin
			closed_reg <= closed_next;
		end
	end

	assign cursor_col   = col_reg;
	assign cursor_row   = row_reg;
	assign col_pulse    = col_pulse_reg;
	assign row_pulse    = row_pulse_reg;
	assign cmd_accepted = accept_reg;
	assign arrow_closed = closed_reg;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_pulse_start;
		$rose(col_pulse_reg) && ($past(char_count) == `CPC_STEP_START);
	endsequence

	sequence s_pulse_end;
		$fell(col_pulse_reg) && ($past(char_count) == `CPC_STEP_END);
	endsequence

	a_col_range: assert property (col_reg <= `CPC_COL_LAST) // RULE1
		else $error("column beyond last position");
	a_row_range: assert property (row_reg <= `CPC_ROW_LAST) // RULE2
		else $error("row beyond last row");
	a_right_step: assert property (col_fire && col_gate && col_up && !clr_col // RULE3
		|=> col_reg == $past(col_reg) + `CPC_COL_W'(1))
		else $error("move right did not advance column by one");
	a_pulse_open: assert property ($rose(col_pulse_reg) |-> s_pulse_start) // RULE4
		else $error("column pulse began away from count 76");
	a_pulse_close: assert property ($fell(col_pulse_reg) |-> s_pulse_end) // RULE4
		else $error("column pulse ended away from count 82");
	a_permit_hold: assert property (!permit && !clr_col |=> $stable(col_reg)) // RULE5
		else $error("column moved without step permit");
	a_col_zero: assert property (col_reg == `CPC_COL_FIRST && !col_up && !clr_col // RULE6
		|=> col_reg == `CPC_COL_FIRST)
		else $error("column went below zero");
	a_accept_set: assert property ($rose(accept_reg) // RULE7
		|-> $past(char_count) == `CPC_STEP_END)
		else $error("acceptance raised away from count 82");
	a_accept_hold: assert property (accept_reg && col_pend && !row_pend // RULE7
		&& (col_st_reg == ST_HELD) |=> accept_reg)
		else $error("acceptance dropped while command still active");
	a_left_step: assert property (col_fire && col_gate && !col_up && !clr_col // RULE8
		|=> col_reg == $past(col_reg) - `CPC_COL_W'(1))
		else $error("move left did not retreat column by one");
	a_up_step: assert property (row_fire && row_gate && row_dec && !clr_all // RULE9
		|=> row_reg == $past(row_reg) - `CPC_ROW_W'(1))
		else $error("move up did not decrement row");
	a_row_top: assert property (row_reg == `CPC_ROW_FIRST && row_dec && !clr_all // RULE10
		|=> row_reg == `CPC_ROW_FIRST)
		else $error("row moved above top");
	a_row_bottom: assert property (row_reg == `CPC_ROW_LAST && !row_dec // RULE11
		|=> row_reg == `CPC_ROW_LAST || row_reg == `CPC_ROW_FIRST)
		else $error("row moved below last row");
	a_down_step: assert property (row_fire && row_gate && !row_dec && !clr_all // RULE12
		|=> row_reg == $past(row_reg) + `CPC_ROW_W'(1))
		else $error("move down did not increment row");
	a_key_closed: assert property (closed_reg == $past(key_closed)) // RULE16
		else $error("closed indication does not follow key");
	a_return_clear: assert property (h_return && !clr_all // RULE17
		|=> col_reg == `CPC_COL_FIRST && row_reg == $past(row_reg))
		else $error("carriage return mishandled counters");
	a_home_clear: assert property (clr_all // RULE18
		|=> col_reg == `CPC_COL_FIRST && row_reg == `CPC_ROW_FIRST)
		else $error("home did not clear both counters");

endmodule
`default_nettype wire

// >>> test/cpc_host_model.sv
// Host interface card and arrow keyboard model for the cursor block
`timescale 1ns/1ps
`default_nettype none

module cpc_host_model (
	// Clock and acceptance
	input  wire logic       ref_clk,
	input  wire logic       cmd_accepted,
	// Host lines: right, left, up, down, return, home
	output logic      [5:0] host_n,
	// Key lines: right, left, up, down, home
	output logic      [4:0] key_n
);
	initial begin
		host_n = 6'h3f;
		key_n  = 5'h1f;
	end

	// Move held low until accepted, then held on for a while (slow host)
	task automatic issue(input int idx, input int hold, output bit ok);
		int n;
		ok = 1'b0;
		@(posedge ref_clk);
		host_n[idx] <= 1'b0;
		for (n = 0; n < 400 && !ok; n++) begin
			@(posedge ref_clk);
			ok = (cmd_accepted === 1'b1);
		end
		repeat (hold) @(posedge ref_clk);
		host_n[idx] <= 1'b1;
		for (n = 0; n < 10 && cmd_accepted !== 1'b0; n++)
			@(posedge ref_clk);
		ok = ok && (cmd_accepted === 1'b0);
	endtask

	// Return and home carry no acceptance
	task automatic pulse(input int idx, input int n);
		@(posedge ref_clk);
		host_n[idx] <= 1'b0;
		repeat (n) @(posedge ref_clk);
		host_n[idx] <= 1'b1;
	endtask

	// Short bounces below the settling time, then a clean closure
	task automatic press(input int idx, input int bounces);
		repeat (bounces) begin
			@(posedge ref_clk);
			key_n[idx] <= 1'b0;
			repeat (3) @(posedge ref_clk);
			key_n[idx] <= 1'b1;
			repeat (2) @(posedge ref_clk);
		end
		@(posedge ref_clk);
		key_n[idx] <= 1'b0;
	endtask

	task automatic release_key(input int idx);
		@(posedge ref_clk);
		key_n[idx] <= 1'b1;
	endtask
endmodule
`default_nettype wire

// >>> test/cpc_top_tb.sv
// Self-checking bench for the cursor position control block
`timescale 1ns/1ps
`default_nettype none
`include "cpc_defs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("mismatch %s expected %0h seen %0h", nm, e, g); end end

module cpc_top_tb;
	logic                    ref_clk = 1'b0;
	logic                    rst = 1'b1;
	logic [`CPC_CHAR_W-1:0]  char_count = 7'h00;
	logic                    power_on_n = 1'b1;
	logic                    step_permit = 1'b1;
	logic                    repeat_clk = 1'b0;
	logic                    rep_en = 1'b0;
	int                      rep_div = 0;
	logic [5:0]              host_n;
	logic [4:0]              key_n;
	logic [`CPC_COL_W-1:0]   cursor_col;
	logic [`CPC_ROW_W-1:0]   cursor_row;
	logic                    col_pulse;
	logic                    row_pulse;
	logic                    cmd_accepted;
	logic [3:0]              arrow_closed;
	logic                    p_prev = 1'b0;
	int                      p_width = 0;
	logic [`CPC_CHAR_W-1:0]  p_rise = 7'h00;
	int                      mismatches = 0;
	int                      total_checks = 0;

	initial forever #50 ref_clk = ~ref_clk;

	// ----------------------------------------------------------------------
	// Line timing, scaled repeat clock and step pulse monitor
	// ----------------------------------------------------------------------
	always @(posedge ref_clk) begin
		char_count <= (char_count == 7'h52) ? 7'h00 : char_count + 7'h01;
		// High phase longer than a line so every repeat window meets count 76
		rep_div <= (rep_div == 99) ? 0 : rep_div + 1;
		if (rep_div == 99)
			repeat_clk <= rep_en & ~repeat_clk;
		p_prev <= col_pulse | row_pulse;
		if ((col_pulse | row_pulse) && !p_prev) begin
			p_width <= 1;
			p_rise  <= char_count;
		end else if (col_pulse | row_pulse)
			p_width <= p_width + 1;
	end

	// Onset longer than a line, so a held key always meets one count 76
	cpc_top #(.DEBOUNCE_CYCLES(8), .REPEAT_CYCLES(100)) cpc_top_i (
		.ref_clk(ref_clk), .rst(rst), .char_count(char_count),
		.host_right_n(host_n[0]), .host_left_n(host_n[1]), .host_up_n(host_n[2]),
		.host_down_n(host_n[3]), .host_return_n(host_n[4]), .host_home_n(host_n[5]),
		.key_right_n(key_n[0]), .key_left_n(key_n[1]), .key_up_n(key_n[2]),
		.key_down_n(key_n[3]), .key_home_n(key_n[4]),
		.power_on_n(power_on_n), .step_permit(step_permit), .repeat_clk(repeat_clk),
		.cursor_col(cursor_col), .cursor_row(cursor_row), .col_pulse(col_pulse),
		.row_pulse(row_pulse), .cmd_accepted(cmd_accepted), .arrow_closed(arrow_closed)
	);

	cpc_host_model cpc_host_model_i (
		.ref_clk(ref_clk), .cmd_accepted(cmd_accepted), .host_n(host_n), .key_n(key_n)
	);

	task automatic end_of_test();
		if (mismatches == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check_pos(input logic [`CPC_COL_W-1:0] c, input logic [`CPC_ROW_W-1:0] r);
		`CHK("cursor_col", c, cursor_col)
		`CHK("cursor_row", r, cursor_row)
	endtask

	// A move that never completes ends the run
	task automatic mv(input int idx, input int hold);
		bit ok;
		cpc_host_model_i.issue(idx, hold, ok);
		`CHK("cmd_accepted", 1'b1, ok)
		if (!ok)
			end_of_test();
	endtask

	// ----------------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------------
	task automatic sc_host_moves();
		int idx[6] = '{1, 2, 0, 3, 1, 2};
		int ec[6]  = '{0, 0, 1, 1, 0, 0};
		int er[6]  = '{0, 0, 0, 1, 1, 0};
		for (int i = 0; i < 6; i++) begin
			mv(idx[i], i);
			check_pos(ec[i][6:0], er[i][4:0]);
			if (i > 1) begin
				`CHK("pulse width", 6, p_width)
				`CHK("pulse start", `CPC_STEP_START + 7'h01, p_rise)
			end
		end
	endtask

	task automatic sc_keys();
		int idx[4] = '{0, 3, 1, 2};
		int ec[4]  = '{1, 1, 0, 0};
		int er[4]  = '{0, 1, 1, 0};
		for (int i = 0; i < 4; i++) begin
			cpc_host_model_i.press(idx[i], 2);
			repeat (5) @(posedge ref_clk);
			`CHK("arrow_closed early", 4'h0, arrow_closed)
			repeat (150) @(posedge ref_clk);
			`CHK("arrow_closed", 4'h1 << idx[i], arrow_closed)
			cpc_host_model_i.release_key(idx[i]);
			repeat (10) @(posedge ref_clk);
			check_pos(ec[i][6:0], er[i][4:0]);
			`CHK("arrow_closed off", 4'h0, arrow_closed)
		end
	endtask

	task automatic sc_repeat();
		rep_en <= 1'b1;
		cpc_host_model_i.press(3, 0);
		repeat (1100) @(posedge ref_clk);
		cpc_host_model_i.release_key(3);
		rep_en <= 1'b0;
		repeat (120) @(posedge ref_clk);
		`CHK("repeat steps", 1'b1, cursor_row >= 5'h04)
		cpc_host_model_i.pulse(5, 4);
		repeat (4) @(posedge ref_clk);
		check_pos(7'h00, 5'h00);
	endtask

	task automatic sc_permit_home();
		@(posedge ref_clk);
		step_permit <= 1'b0;
		mv(0, 0);
		check_pos(7'h00, 5'h00);
		step_permit <= 1'b1;
		mv(0, 0);
		mv(3, 0);
		check_pos(7'h01, 5'h01);
		cpc_host_model_i.press(4, 0);
		repeat (4) @(posedge ref_clk);
		cpc_host_model_i.release_key(4);
		repeat (4) @(posedge ref_clk);
		check_pos(7'h00, 5'h00);
		mv(0, 0);
		power_on_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		power_on_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		check_pos(7'h00, 5'h00);
	endtask

	task automatic sc_limits();
		for (int i = 0; i < 72; i++)
			mv(0, 0);
		for (int i = 0; i < 25; i++)
			mv(3, 0);
		check_pos(`CPC_COL_LAST, `CPC_ROW_LAST);
		cpc_host_model_i.pulse(4, 4);
		repeat (4) @(posedge ref_clk);
		check_pos(7'h00, `CPC_ROW_LAST);
		cpc_host_model_i.pulse(5, 4);
		repeat (4) @(posedge ref_clk);
		check_pos(7'h00, 5'h00);
	endtask

	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check_pos(7'h00, 5'h00);
		sc_host_moves();
		sc_keys();
		sc_repeat();
		sc_permit_home();
		sc_limits();
		end_of_test();
	end
endmodule
`default_nettype wire
